// ---- rtl/wdt_core.sv ----
// Purpose: watchdog timer with key enable, clock choice and sleep wake-up
// Assumes: classic wishbone slave, 50 MHz clk_i, slow rc clock as a pin level
// Notes: overflow and bad-key resets are pulses to the reset controller
// Contract
// [R1] period code sets divide 2^8 to 2^15
// [R2] code 111, the reset value, divides 32768
// [R3] clock choice: 00 slow rc, 01 div4, else sys
// [R4] key 000000 enables, 101101 disables, resets zero
// [R5] other key resets device after 2-3 slow cycles; code fires at the second slow rc edge, 1-2 slow cycles after the key
// [R6] overflow awake resets device, sets timeout flag
// [R7] overflow asleep wakes, sets flag, clears pc/sp
// [R8] system-clock sources stop counting during sleep
// [R9] software prefers slow rc in noisy systems
// [R10] count cleared by bad key, pin, clear, halt
// [R11] software must clear before overflow
// [R12] disabled watchdog: instructions are no-ops; code gates only clear, halt still acts
// [R13] halt clears count, sets powerdown, clears timeout
// [R14] slow rc keeps counting during sleep
// [R15] sleep timeout leaves timeout and powerdown set
// [R16] 15-bit counter, overflow at selected bit
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module wdt_core
   import wdt_pkg::*;
#(
   parameter int CNT_W = 15
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // pins: slow rc clock level, external reset (active low)
   input wire logic slow_rc_clock_i,
   input wire logic ext_rst_pin_n_i,
   // device status
   input wire logic sleep_i,
   // reset requests and wake
   output logic device_reset_o,
   output logic pc_sp_clear_o,
   output logic wake_o,
   // interrupt
   output logic irq_o
);
   import wdt_pkg::*;

   // the overflow decode below is written out for a 15-bit count only
   if (CNT_W != 15) begin : g_bad_width
      $error("wdt_core supports a 15-bit counter only");
   end

   // synchronised pins
   logic [1:0] pins_s;
   logic slow_s;
   logic pin_rst_n;
   wdt_sync2 #(.WIDTH(2)) wdt_sync2_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({slow_rc_clock_i, ext_rst_pin_n_i}),
      .rst_val_i(2'b01),
      .sync_o(pins_s)
   );
   assign slow_s = pins_s[1];
   assign pin_rst_n = pins_s[0];

   // registers
   logic [2:0] period_code; // period_select_reg
   logic [1:0] wd_clock_choice; // upper watchdog_ctrl_reg
   logic [5:0] enable_key; // lower watchdog_ctrl_reg
   logic timeout_flag;
   logic powerdown_flag;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [CNT_W-1:0] count;
   logic slow_d; // previous synchronised slow level
   logic [1:0] div4;
   logic ack;
   logic [31:0] rdata;
   key_state_type key_state;
   logic [1:0] key_cnt;

   logic [2:0] next_period_code;
   logic [1:0] next_wd_clock_choice;
   logic [5:0] next_enable_key;
   logic next_timeout_flag;
   logic next_powerdown_flag;
   logic [1:0] next_irq_stat;
   logic [1:0] next_irq_mask;
   logic [CNT_W-1:0] next_count;
   logic [1:0] next_div4;
   logic next_ack;
   logic [31:0] next_rdata;
   key_state_type next_key_state;
   logic [1:0] next_key_cnt;

   // decoded bus strokes
   logic wr_stb, rd_stb;
   logic wr_period, wr_ctrl, wr_flags, wr_stat, wr_mask, wr_cmd;
   logic clear_watchdog_instr, halt_instr;
   logic enabled, bad_key, slow_tick, tick, overflow, overflow_bit;

   // writes land at the edge where the master sees ack high, never earlier
   assign wr_stb = cyc_i & stb_i & we_i & ack & sel_i[0];
   assign rd_stb = cyc_i & stb_i & ~we_i & ~ack;
   // address decoding, second bank selected by sel lane 1 at adr 0 and 4
   always_comb begin
      wr_period = 1'b0;
      wr_ctrl = 1'b0;
      wr_flags = 1'b0;
      wr_stat = 1'b0;
      if (wr_stb && adr_i == 4'h0) begin
         wr_period = 1'b1;
      end else if (wr_stb && adr_i == 4'h4) begin
         wr_ctrl = 1'b1;
      end else if (wr_stb && adr_i == 4'h8) begin
         wr_flags = 1'b1;
      end else if (wr_stb && adr_i == 4'hc) begin
         wr_stat = 1'b1;
      end
   end
   // mask and command live in an upper word pair reached through sel lane 1
   assign wr_mask = cyc_i & stb_i & we_i & ack & sel_i[1] & (adr_i == 4'h0);
   assign wr_cmd = cyc_i & stb_i & we_i & ack & sel_i[1] & (adr_i == 4'h4);

   // watchdog is live only under the enable key
   assign enabled = (enable_key == `WDT_KEY_ENABLE); // see [R4]
   // clear acts only while enabled, otherwise a no-op; halt acts regardless
   assign clear_watchdog_instr = wr_cmd & dat_i[8 + `WDT_CMD_CLEAR_BIT] & enabled; // see [R12]
   assign halt_instr = wr_cmd & dat_i[8 + `WDT_CMD_HALT_BIT];
   assign bad_key = (enable_key != `WDT_KEY_ENABLE) &&
                    (enable_key != `WDT_KEY_DISABLE); // see [R5]

   // clock source tick; system sources stop while asleep
   assign slow_tick = slow_s & ~slow_d;
   always_comb begin
      if (wd_clock_choice == `WDT_CLK_SLOW) begin
         tick = slow_tick; // see [R3] [R14]
      end else if (wd_clock_choice == `WDT_CLK_DIV4) begin
         tick = (div4 == 2'h3) & ~sleep_i; // see [R3] [R8]
      end else begin
         tick = ~sleep_i; // see [R8]
      end
   end

   // overflow bit picked by period code
   always_comb begin
      case (period_code)
         3'h0, 3'h1: overflow_bit = &count[7:0]; // see [R1]
         3'h2: overflow_bit = &count[9:0];
         3'h3: overflow_bit = &count[10:0];
         3'h4: overflow_bit = &count[11:0];
         3'h5: overflow_bit = &count[12:0];
         3'h6: overflow_bit = &count[13:0];
         default: overflow_bit = &count[14:0]; // see [R2]
      endcase
   end
   assign overflow = enabled & tick & overflow_bit; // see [R16]

   // counter, divider and key sequence next values
   always_comb begin
      next_count = count;
      next_div4 = div4 + 2'h1;
      next_key_state = key_state;
      next_key_cnt = key_cnt;
      if (!pin_rst_n || halt_instr || clear_watchdog_instr || bad_key || overflow) begin
         next_count = '0; // see [R10] [R11] [R13]
      end else if (enabled && tick) begin
         next_count = count + 15'h1; // see [R16]
      end
      // bad key: count slow rc edges, fire at the second
      case (key_state)
         KEY_IDLE: begin
            next_key_cnt = 2'h0;
            if (bad_key) next_key_state = KEY_WAIT;
         end
         KEY_WAIT: begin
            if (!bad_key) begin
               next_key_state = KEY_IDLE;
            end else if (slow_tick) begin
               next_key_cnt = key_cnt + 2'h1;
               if (key_cnt + 2'h1 == `WDT_KEY_RST_CYC) next_key_state = KEY_FIRE; // see [R5]
            end
         end
         KEY_FIRE: next_key_state = KEY_IDLE;
         default: next_key_state = KEY_IDLE;
      endcase
   end

   // register writes, flags and interrupts
   always_comb begin
      next_period_code = wr_period ? dat_i[2:0] : period_code;
      next_wd_clock_choice = wr_ctrl ? dat_i[7:6] : wd_clock_choice;
      next_enable_key = wr_ctrl ? dat_i[5:0] : enable_key; // see [R4]
      next_irq_mask = wr_mask ? dat_i[9:8] : irq_mask;
      next_timeout_flag = timeout_flag;
      next_powerdown_flag = powerdown_flag;
      if (wr_flags) begin
         next_timeout_flag = dat_i[`WDT_FLAG_TO_BIT];
         next_powerdown_flag = dat_i[`WDT_FLAG_PD_BIT];
      end
      if (clear_watchdog_instr) next_powerdown_flag = 1'b0;
      if (halt_instr) begin
         next_powerdown_flag = 1'b1; // see [R13]
         next_timeout_flag = 1'b0; // see [R13]
      end
      // overflow wins over any clear in the same cycle
      if (overflow) next_timeout_flag = 1'b1; // see [R6] [R7] [R15]
      next_irq_stat = irq_stat & ~(wr_stat ? dat_i[1:0] : 2'h0);
      if (overflow) next_irq_stat[`WDT_IRQ_TIMEOUT_BIT] = 1'b1;
      if (key_state == KEY_FIRE) next_irq_stat[`WDT_IRQ_KEY_BIT] = 1'b1;
      next_ack = cyc_i & stb_i & ~ack;
      next_rdata = rdata;
      if (rd_stb) begin
         if (adr_i == 4'h0) begin
            next_rdata = {16'h0, 6'h0, irq_mask, 5'h0, period_code};
         end else if (adr_i == 4'h4) begin
            next_rdata = {24'h0, wd_clock_choice, enable_key};
         end else if (adr_i == 4'h8) begin
            next_rdata = {15'h0, count, powerdown_flag, timeout_flag};
         end else if (adr_i == 4'hc) begin
            next_rdata = {30'h0, irq_stat};
         end else begin
            next_rdata = 32'h0;
         end
      end
   end

   // main register process; output pulse flops follow
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         period_code <= `WDT_PERIOD_RST; // see [R2]
         wd_clock_choice <= 2'(`WDT_CTRL_RST >> 6);
         enable_key <= 6'h00; // see [R4]
         timeout_flag <= 1'b0;
         powerdown_flag <= 1'b0;
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
         count <= '0;
         slow_d <= 1'b0;
         div4 <= 2'h0;
         ack <= 1'b0;
         rdata <= 32'h0;
         key_state <= KEY_IDLE;
         key_cnt <= 2'h0;
      end else begin
         period_code <= next_period_code;
         wd_clock_choice <= next_wd_clock_choice;
         enable_key <= next_enable_key;
         timeout_flag <= next_timeout_flag;
         powerdown_flag <= next_powerdown_flag;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         count <= next_count;
         slow_d <= slow_s;
         div4 <= next_div4;
         ack <= next_ack;
         rdata <= next_rdata;
         key_state <= next_key_state;
         key_cnt <= next_key_cnt;
      end
   end

   // outputs: reset pulse when awake, wake plus pc/sp clear when asleep
   logic dev_rst_q, pcsp_q, wake_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dev_rst_q <= 1'b0;
         pcsp_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         dev_rst_q <= (overflow & ~sleep_i) | (key_state == KEY_FIRE); // see [R5] [R6]
         pcsp_q <= overflow & sleep_i; // see [R7]
         wake_q <= overflow & sleep_i; // see [R7]
      end
   end
   assign device_reset_o = dev_rst_q;
   assign pc_sp_clear_o = pcsp_q;
   assign wake_o = wake_q;
   assign ack_o = ack;
   assign dat_o = rdata;
   assign irq_o = |(irq_stat & irq_mask);

   // assertions
   a_halt_flags: assert property (@(posedge clk_i) disable iff (rst_i) // see [R13]
      halt_instr && !overflow |=> powerdown_flag && !timeout_flag)
      else $error("halt did not set powerdown and clear timeout");
   a_overflow_flag: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6]
      overflow |=> timeout_flag)
      else $error("overflow did not set timeout flag");
   a_sleep_wake: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
      overflow && sleep_i |=> wake_o && pc_sp_clear_o && !device_reset_o)
      else $error("sleep overflow did not wake");
   a_awake_reset: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6]
      overflow && !sleep_i |=> device_reset_o)
      else $error("overflow did not reset device");
   a_disabled_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see [R12]
      !enabled && !bad_key && pin_rst_n && !halt_instr |=> $stable(count))
      else $error("disabled counter moved");
   a_sleep_sys_stop: assert property (@(posedge clk_i) disable iff (rst_i) // see [R8]
      sleep_i && wd_clock_choice != `WDT_CLK_SLOW |-> !tick)
      else $error("system source ticked asleep");
   a_clear_count: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
      clear_watchdog_instr |=> count == '0)
      else $error("clear did not zero counter");
   a_key_reset: assert property (@(posedge clk_i) disable iff (rst_i) // see [R5]
      key_state == KEY_FIRE |=> device_reset_o)
      else $error("bad key did not reset");
endmodule
`default_nettype wire

// ---- rtl/wdt_map.svh ----
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: classic wishbone, 32-bit data, word-aligned registers
// Notes: definitions only
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_ADR_PERIOD 4'h0
`define WDT_ADR_CTRL 4'h4
`define WDT_ADR_FLAGS 4'h8
`define WDT_ADR_IRQ_STAT 4'hc
`define WDT_ADR_IRQ_MASK 4'h0
`define WDT_ADR_CMD 4'h4
`define WDT_ADR_HI_IRQ_MASK 1'b1
`define WDT_PERIOD_RST 3'h7
`define WDT_CTRL_RST 8'h00
`define WDT_KEY_ENABLE 6'h00
`define WDT_KEY_DISABLE 6'h2d
`define WDT_CLK_SLOW 2'h0
`define WDT_CLK_DIV4 2'h1
`define WDT_CMD_CLEAR_BIT 0
`define WDT_CMD_HALT_BIT 1
`define WDT_FLAG_TO_BIT 0
`define WDT_FLAG_PD_BIT 1
`define WDT_IRQ_TIMEOUT_BIT 0
`define WDT_IRQ_KEY_BIT 1
`define WDT_KEY_RST_CYC 2'h2
`define WDT_SLOW_PERIOD_NS 83333
`endif

// ---- rtl/wdt_pkg.sv ----
// Purpose: shared types of the watchdog
// Assumes: nothing
// Notes: constants live in wdt_map.svh
package wdt_pkg;
   // state of the bad-key reset sequence
   typedef enum logic [2:0] {
      KEY_IDLE = 3'b001,
      KEY_WAIT = 3'b010,
      KEY_FIRE = 3'b100
   } key_state_type;
endpackage

// ---- rtl/wdt_sync2.sv ----
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: single destination clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module wdt_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // asynchronous level in, synchronised level out
   input wire logic [WIDTH-1:0] async_i,
   input wire logic [WIDTH-1:0] rst_val_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta; // first stage, read only by the second stage
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync;

   // reset value is applied synchronously; rst_val_i is a tie-off constant
   always_comb begin
      next_meta = rst_i ? rst_val_i : async_i;
      next_sync = rst_i ? rst_val_i : meta;
   end

   // register both stages
   always_ff @(posedge clk_i) begin
      meta <= next_meta;
      sync_o <= next_sync;
   end
endmodule
`default_nettype wire

// ---- tb/test_wdt_core.sv ----
// Purpose: self-checking bench for the watchdog core
// Assumes: slow rc level sped up to 16 clk periods, 1-cycle wishbone answer
// Notes: reads are scored through a queue, pulse timing by cycle windows
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module test_wdt_core;
   import wdt_pkg::*;
   // clock, reset and bus
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic ack_o, device_reset_o, pc_sp_clear_o, wake_o, irq_o;
   // pins and sleep state
   logic slow_rc_clock_i = 1'b0, ext_rst_pin_n_i = 1'b1, sleep_i = 1'b0;
   // scoreboard of expected read data and masks
   logic [31:0] exp_q[$], msk_q[$];
   logic [31:0] seed = 32'h00011861;
   int error_cnt = 0, cmp_count = 0;
   wdt_core #(.CNT_W(15)) wdt_core_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .slow_rc_clock_i(slow_rc_clock_i),
      .ext_rst_pin_n_i(ext_rst_pin_n_i), .sleep_i(sleep_i),
      .device_reset_o(device_reset_o), .pc_sp_clear_o(pc_sp_clear_o),
      .wake_o(wake_o), .irq_o(irq_o));
   // 50 mhz system clock
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   // slow rc free runs, also in sleep; far faster than real to keep the run short
   initial begin
      forever begin
         repeat (8) @(posedge clk_i);
         slow_rc_clock_i <= ~slow_rc_clock_i;
      end
   end
   // xorshift step for random data bits and gaps
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // verdict, the one exit of the run
   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // compare read data under a mask
   task automatic chk_rd(input logic [31:0] e, input logic [31:0] m);
      cmp_count++;
      if ((dat_o & m) !== e) begin
         error_cnt++;
         $display("[FAIL] read data exp %h got %h", e, dat_o & m);
      end
   endtask
   // compare a cycle count against a window
   task automatic chk_n(input string nm, input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, hi, got);
      end
   endtask
   // compare a single output bit
   task automatic chk_b(input string nm, input logic e, input logic got);
      cmp_count++;
      if (got !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %b got %b", nm, e, got);
      end
   endtask
   // classic cycle: hold everything until ack is sampled, release after
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
      int i;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      if (!w) begin
         exp_q.push_back(e);
         msk_q.push_back(m);
      end
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack_o !== 1'b1 && i < 20);
      if (i >= 20) begin
         error_cnt++;
         results();
      end else begin
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i <= 1'b0;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
      wb(1'b1, a, s, d, 32'h0, 32'h0);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      wb(1'b0, a, 4'hf, 32'h0, e, m);
   endtask
   // clear-watchdog command on byte lane 1
   task automatic clr();
      wr(`WDT_ADR_CMD, 4'h2, 32'h100);
   endtask
   // cycles until reset (w 0) or wake (w 1) pulse, bounded
   task automatic meas(input int w, output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (((w == 0) ? device_reset_o : wake_o) !== 1'b1 && n < 40000);
      if (n >= 40000) begin
         error_cnt++;
         results();
      end
   endtask
   // no reset or wake pulse for n cycles
   task automatic quiet(input int n);
      int h;
      h = 0;
      repeat (n) begin
         @(posedge clk_i);
         if (device_reset_o !== 1'b0 || wake_o !== 1'b0)
            h++;
      end
      chk_n("stray pulses", h, 0, 0);
   endtask
   // read monitor: oldest note against each read answer
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && cyc_i && !we_i && exp_q.size() > 0)
         chk_rd(exp_q.pop_front(), msk_q.pop_front());
   end
   // main sequence
   initial begin
      int c, n, e, k;
      int ck[3] = '{1, 3, 0};
      int cy[3] = '{1024, 256, 4096};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(`WDT_ADR_PERIOD, 32'h7, 32'h3ff);
      rd(`WDT_ADR_CTRL, 32'h0, 32'hff);
      rd(`WDT_ADR_FLAGS, 32'h0, 32'h3);
      wr(`WDT_ADR_IRQ_MASK, 4'h2, 32'h300);
      wr(`WDT_ADR_CTRL, 4'h1, 32'h80);
      // every period code on the system clock; the longest takes about 33k cycles
      for (c = 0; c < 8; c++) begin
         seed = xs(seed);
         wr(`WDT_ADR_PERIOD, 4'h1, {seed[31:3], 3'(c)});
         clr();
         meas(0, n);
         e = (c < 2) ? 256 : (1 << (c + 8));
         chk_n("overflow cycles", n, e - 4, e + 4);
      end
      @(negedge clk_i);
      chk_b("irq", 1'b1, irq_o);
      rd(`WDT_ADR_FLAGS, 32'h1, 32'h1);
      // clock choices at the shortest period; slow edge phase widens the window
      wr(`WDT_ADR_PERIOD, 4'h1, 32'h0);
      for (k = 0; k < 3; k++) begin
         wr(`WDT_ADR_CTRL, 4'h1, 32'(ck[k]) << 6);
         clr();
         meas(0, n);
         chk_n("choice cycles", n, cy[k] - cy[k] / 32 - 4, cy[k] + cy[k] / 32 + 4);
      end
      // disabled: no overflow, clear does nothing
      wr(`WDT_ADR_CTRL, 4'h1, 32'had);
      clr();
      quiet(700);
      rd(`WDT_ADR_CTRL, 32'had, 32'hff);
      wr(`WDT_ADR_IRQ_STAT, 4'h1, 32'h3);
      @(negedge clk_i);
      chk_b("irq after clear", 1'b0, irq_o);
      rd(`WDT_ADR_IRQ_STAT, 32'h0, 32'h3);
      // bad key fires after two slow edges
      wr(`WDT_ADR_CTRL, 4'h1, 32'h95);
      meas(0, n);
      chk_n("bad key delay", n, 17, 44);
      wr(`WDT_ADR_CTRL, 4'h1, 32'h80);
      wr(`WDT_ADR_IRQ_MASK, 4'h2, 32'h0);
      rd(`WDT_ADR_IRQ_STAT, 32'h2, 32'h2);
      @(negedge clk_i);
      chk_b("irq masked", 1'b0, irq_o);
      // pin low restarts the count at a random point
      wr(`WDT_ADR_PERIOD, 4'h1, 32'h2);
      clr();
      seed = xs(seed);
      repeat (300 + seed[8:0]) @(posedge clk_i);
      ext_rst_pin_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      ext_rst_pin_n_i <= 1'b1;
      meas(0, n);
      chk_n("pin clear", n, 1010, 1036);
      // sleep on the system clock halts the count
      wr(`WDT_ADR_PERIOD, 4'h1, 32'h0);
      sleep_i <= 1'b1;
      clr();
      quiet(700);
      // sleep on slow rc, the noise-safe choice: halt, then wake instead of reset
      wr(`WDT_ADR_CTRL, 4'h1, 32'h00);
      wr(`WDT_ADR_CMD, 4'h2, 32'h200);
      rd(`WDT_ADR_FLAGS, 32'h2, 32'h3);
      meas(1, n);
      chk_n("sleep wake", n, 3940, 4240);
      chk_b("pc sp clear", 1'b1, pc_sp_clear_o);
      chk_b("no reset in sleep", 1'b0, device_reset_o);
      rd(`WDT_ADR_FLAGS, 32'h3, 32'h3);
      sleep_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      results();
   end
endmodule
`default_nettype wire
